// File: verilog/motion_io_params.svh
`ifndef MOTION_IO_PARAMS_SVH
`define MOTION_IO_PARAMS_SVH

// ----------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_JOG_SPEED 4'h1
`define OFS_STATUS 4'h2
`define OFS_IRQ_STATUS 4'h3
`define OFS_IRQ_MASK 4'h4
`define OFS_WARN 4'h5
`define OFS_TASK 4'h6

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_BASE_HOMING 0
`define CTRL_BASE_ADV 1
`define CTRL_BASE_RESUME 2
`define CTRL_SEQ_MODE_LO 3
`define CTRL_SEQ_MODE_HI 4
`define CTRL_FLAG0_EN 5
`define CTRL_FLAG5_EN 6
`define CTRL_WIDTH 7
`define CTRL_RESET 7'h00

// ----------------------------------------------------------------
// sequence-step output modes
// ----------------------------------------------------------------
`define SEQ_MODE_TOGGLE 2'h0
`define SEQ_MODE_TARGET_REACHED_OUTPUT 2'h1
`define SEQ_MODE_LOW 2'h2
`define SEQ_MODE_HIGH 2'h3

// ----------------------------------------------------------------
// interrupt and warning bits
// ----------------------------------------------------------------
`define IRQ_TASK_START 0
`define IRQ_TARGET 1
`define IRQ_LAG_FAULT 2
`define IRQ_HOMING 3
`define IRQ_WIDTH 4
`define WARN_LAG 0
`define WARN_RESP 1
`define WARN_WIDTH 2

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define TASK_W 8
`define JOG_W 16
`define JOG_SPEED_RESET 16'h0000
`define FLAG_COUNT 6
`define SYNC_W 14

`endif

// File: verilog/motion_io_pkg.sv
package motion_io_pkg;

  typedef logic [7:0] task_num_t;

  typedef enum logic [0:0] {
    adv_idle,
    adv_wait
  } adv_state_t;

endpackage

// File: verilog/motion_task_io_card.sv
// Operation
// [RULE1] base homing selected: card homing ignored
// [RULE2] clear input clears lag/response warnings
// [RULE3] advance starts next task after target reached
// [RULE4] base-unit input may also advance task
// [RULE5] jog speed from register, sign is direction
// [RULE6] jog rising edge starts, falling edge cancels
// [RULE7] resume continues interrupted task, base too
// [RULE8] start takes task number from select inputs
// [RULE9] base start takes number from base inputs
// [RULE10] in-position output high inside target window
// [RULE11] no cable-break detection on in-position output
// [RULE12] sequence step output toggles per chained start
// [RULE13] sequence step low at first chained task
// [RULE14] sequence step behaviour set by software
// [RULE15] lag output low outside following window
// [RULE16] position flag high when preset fulfilled
// [RULE17] flags zero and five software configured only
// [RULE18] select bit low is lsb, high msb
// [RULE19] inputs synchronised and edge detected first
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "motion_io_params.svh"

module motion_task_io_card
  import motion_io_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // controller pins on the card
  input wire logic [7:0] task_select_i,
  input wire logic homing_switch_i,
  input wire logic lag_warning_clear_i,
  input wire logic advance_task_input_i,
  input wire logic jog_input_i,
  input wire logic resume_task_input_i,
  input wire logic task_start_input_i,
  // base-unit digital inputs
  input wire logic [7:0] base_task_select_i,
  input wire logic base_homing_i,
  input wire logic base_task_start_i,
  input wire logic base_advance_i,
  input wire logic base_resume_i,
  // motion core status
  input wire logic target_in_window_i,
  input wire logic lag_in_window_i,
  input wire logic [5:0] preset_met_i,
  input wire logic seq_task_start_i,
  input wire logic seq_first_task_i,
  input wire logic task_interrupted_i,
  input wire logic lag_warn_set_i,
  input wire logic resp_warn_set_i,
  // motion core commands
  output logic start_task_o,
  output logic [7:0] task_num_o,
  output logic advance_o,
  output logic resume_o,
  output logic homing_o,
  output logic jog_run_o,
  output logic [15:0] jog_speed_o,
  output logic jog_dir_o,
  // controller pins driven by the card
  output logic target_reached_output_o,
  output logic sequence_step_output_o,
  output logic lag_fault_output_o,
  output logic [5:0] position_flag_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [`SYNC_W-1:0] pins_raw;
  logic [`SYNC_W-1:0] meta_r;
  logic [`SYNC_W-1:0] sync_r;
  logic [`SYNC_W-1:0] prev_r;
  logic [`SYNC_W-1:0] rise;
  logic [`SYNC_W-1:0] fall;

  // [RULE18] select bit low is lsb
  assign pins_raw = {task_start_input_i, resume_task_input_i, jog_input_i,
                     advance_task_input_i, lag_warning_clear_i, homing_switch_i,
                     task_select_i};

  // [RULE19] two flops then edge detect
  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= pins_raw[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
      assign rise[gi] = sync_r[gi] & ~prev_r[gi];
      assign fall[gi] = ~sync_r[gi] & prev_r[gi];
    end
  endgenerate

  logic [7:0] sel_sync;
  logic homing_sync;
  logic clear_rise;
  logic adv_rise;
  logic jog_sync;
  logic jog_rise;
  logic jog_fall;
  logic resume_rise;
  logic start_rise;

  assign sel_sync = sync_r[7:0];
  assign homing_sync = sync_r[8];
  assign clear_rise = rise[9];
  assign adv_rise = rise[10];
  assign jog_sync = sync_r[11];
  assign jog_rise = rise[11];
  assign jog_fall = fall[11];
  assign resume_rise = rise[12];
  assign start_rise = rise[13];

  // base-unit inputs are internal and already on this clock
  logic base_start_r;
  logic base_adv_r;
  logic base_resume_r;
  logic base_start_rise;
  logic base_adv_rise;
  logic base_resume_rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_start_r <= 1'b0;
      base_adv_r <= 1'b0;
      base_resume_r <= 1'b0;
    end else begin
      base_start_r <= base_task_start_i;
      base_adv_r <= base_advance_i;
      base_resume_r <= base_resume_i;
    end
  end

  assign base_start_rise = base_task_start_i & ~base_start_r;
  assign base_adv_rise = base_advance_i & ~base_adv_r;
  assign base_resume_rise = base_resume_i & ~base_resume_r;

  // ----------------------------------------------------------------
  // registers and bus access
  // ----------------------------------------------------------------
  logic [`CTRL_WIDTH-1:0] ctrl_r;
  logic [`JOG_W-1:0] jog_speed_r;
  logic [`IRQ_WIDTH-1:0] irq_status_r;
  logic [`IRQ_WIDTH-1:0] irq_mask_r;
  logic [`WARN_WIDTH-1:0] warn_r;
  logic [`IRQ_WIDTH-1:0] irq_event;
  logic bus_req;
  logic bus_wr;
  logic [1:0] seq_mode;
  adv_state_t adv_state_r;

  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // one wait cycle: request seen, then waitrequest drops for one cycle
  assign bus_req = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  assign bus_wr = avs_write_i & ~avs_waitrequest_o;
  assign seq_mode = ctrl_r[`CTRL_SEQ_MODE_HI:`CTRL_SEQ_MODE_LO];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~bus_req;
    end
  end

  // [RULE14] step output mode and flag config by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `CTRL_RESET;
      jog_speed_r <= `JOG_SPEED_RESET;
      irq_mask_r <= '0;
    end else if (bus_wr) begin
      if (addr_is(avs_address_i, `OFS_CTRL)) begin
        ctrl_r <= avs_writedata_i[`CTRL_WIDTH-1:0];
      end else if (addr_is(avs_address_i, `OFS_JOG_SPEED)) begin
        jog_speed_r <= avs_writedata_i[`JOG_W-1:0];
      end else if (addr_is(avs_address_i, `OFS_IRQ_MASK)) begin
        irq_mask_r <= avs_writedata_i[`IRQ_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (bus_req && avs_read_i) begin
      if (addr_is(avs_address_i, `OFS_CTRL)) begin
        avs_readdata_o <= {25'h0000000, ctrl_r};
      end else if (addr_is(avs_address_i, `OFS_JOG_SPEED)) begin
        avs_readdata_o <= {16'h0000, jog_speed_r};
      end else if (addr_is(avs_address_i, `OFS_STATUS)) begin
        avs_readdata_o <= {20'h00000, position_flag_o, jog_run_o, adv_state_r == adv_wait,
                           lag_fault_output_o, sequence_step_output_o,
                           target_reached_output_o, homing_o};
      end else if (addr_is(avs_address_i, `OFS_IRQ_STATUS)) begin
        avs_readdata_o <= {28'h0000000, irq_status_r};
      end else if (addr_is(avs_address_i, `OFS_IRQ_MASK)) begin
        avs_readdata_o <= {28'h0000000, irq_mask_r};
      end else if (addr_is(avs_address_i, `OFS_WARN)) begin
        avs_readdata_o <= {30'h00000000, warn_r};
      end else if (addr_is(avs_address_i, `OFS_TASK)) begin
        avs_readdata_o <= {24'h000000, task_num_o};
      end else begin
        avs_readdata_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // warnings
  // ----------------------------------------------------------------
  // [RULE2] clear edge drops warnings, new set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_r <= '0;
    end else begin
      warn_r[`WARN_LAG] <= lag_warn_set_i | (warn_r[`WARN_LAG] & ~clear_rise);
      warn_r[`WARN_RESP] <= resp_warn_set_i | (warn_r[`WARN_RESP] & ~clear_rise);
    end
  end

  // ----------------------------------------------------------------
  // task start and resume
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_task_o <= 1'b0;
      task_num_o <= 8'h00;
    end else begin
      start_task_o <= start_rise | base_start_rise;
      // [RULE8] card start latches select inputs
      if (start_rise) begin
        task_num_o <= sel_sync;
      // [RULE9] base start uses base inputs
      end else if (base_start_rise) begin
        task_num_o <= base_task_select_i;
      end
    end
  end

  // [RULE7] resume only an interrupted task
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resume_o <= 1'b0;
    end else begin
      resume_o <= task_interrupted_i &
                  (resume_rise | (base_resume_rise & ctrl_r[`CTRL_BASE_RESUME]));
    end
  end

  // ----------------------------------------------------------------
  // advance to follow-on task
  // ----------------------------------------------------------------
  logic adv_req;

  // [RULE4] base input gated by its enable
  assign adv_req = adv_rise | (base_adv_rise & ctrl_r[`CTRL_BASE_ADV]);

  // [RULE3] hold the request until target reached
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_state_r <= adv_idle;
      advance_o <= 1'b0;
    end else begin
      advance_o <= 1'b0;
      case (adv_state_r)
        adv_idle: begin
          if (adv_req) begin
            if (target_in_window_i) begin
              advance_o <= 1'b1;
            end else begin
              adv_state_r <= adv_wait;
            end
          end
        end
        adv_wait: begin
          if (target_in_window_i) begin
            advance_o <= 1'b1;
            adv_state_r <= adv_idle;
          end
        end
        default: begin
          adv_state_r <= adv_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // homing and jog
  // ----------------------------------------------------------------
  // [RULE1] base homing overrides card pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      homing_o <= 1'b0;
    end else if (ctrl_r[`CTRL_BASE_HOMING]) begin
      homing_o <= base_homing_i;
    end else begin
      homing_o <= homing_sync;
    end
  end

  // [RULE6] edges start and cancel jog
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jog_run_o <= 1'b0;
    end else if (jog_rise) begin
      jog_run_o <= 1'b1;
    end else if (jog_fall) begin
      jog_run_o <= 1'b0;
    end
  end

  // [RULE5] magnitude and sign of speed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jog_speed_o <= 16'h0000;
      jog_dir_o <= 1'b0;
    end else begin
      jog_dir_o <= jog_speed_r[`JOG_W-1];
      if (jog_speed_r[`JOG_W-1]) begin
        jog_speed_o <= 16'(-jog_speed_r);
      end else begin
        jog_speed_o <= jog_speed_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // controller outputs
  // ----------------------------------------------------------------
  // [RULE10] plain level, [RULE11] no load sensing by design
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_reached_output_o <= 1'b0;
    end else begin
      target_reached_output_o <= target_in_window_i;
    end
  end

  // [RULE15] high only inside following window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lag_fault_output_o <= 1'b0;
    end else begin
      lag_fault_output_o <= lag_in_window_i;
    end
  end

  logic seq_toggle_r;

  // [RULE12] toggle per chained start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_toggle_r <= 1'b0;
    end else if (seq_task_start_i) begin
      // [RULE13] first task of sequence forces low
      seq_toggle_r <= seq_first_task_i ? 1'b0 : ~seq_toggle_r;
    end
  end

  // [RULE14] output form chosen by mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sequence_step_output_o <= 1'b0;
    end else begin
      case (seq_mode)
        `SEQ_MODE_TOGGLE: begin
          if (seq_task_start_i) begin
            sequence_step_output_o <= seq_first_task_i ? 1'b0 : ~seq_toggle_r;
          end else begin
            sequence_step_output_o <= seq_toggle_r;
          end
        end
        `SEQ_MODE_TARGET_REACHED_OUTPUT: sequence_step_output_o <= target_in_window_i;
        `SEQ_MODE_LOW: sequence_step_output_o <= 1'b0;
        default: sequence_step_output_o <= 1'b1;
      endcase
    end
  end

  // [RULE16] flags follow preset results
  // [RULE17] flags zero and five need a software enable
  generate
    for (gi = 0; gi < `FLAG_COUNT; gi = gi + 1) begin : g_flag
      logic flag_en;
      if (gi == 0) begin : g_en0
        assign flag_en = ctrl_r[`CTRL_FLAG0_EN];
      end else if (gi == `FLAG_COUNT - 1) begin : g_en5
        assign flag_en = ctrl_r[`CTRL_FLAG5_EN];
      end else begin : g_enx
        assign flag_en = 1'b1;
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          position_flag_o[gi] <= 1'b0;
        end else begin
          position_flag_o[gi] <= preset_met_i[gi] & flag_en;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic target_prev_r;
  logic lag_prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_prev_r <= 1'b0;
      lag_prev_r <= 1'b1;
    end else begin
      target_prev_r <= target_in_window_i;
      lag_prev_r <= lag_in_window_i;
    end
  end

  assign irq_event[`IRQ_TASK_START] = start_rise | base_start_rise;
  assign irq_event[`IRQ_TARGET] = target_in_window_i & ~target_prev_r;
  assign irq_event[`IRQ_LAG_FAULT] = ~lag_in_window_i & lag_prev_r;
  assign irq_event[`IRQ_HOMING] = homing_o;

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= '0;
    end else if (bus_wr && addr_is(avs_address_i, `OFS_IRQ_STATUS)) begin
      irq_status_r <= irq_event | (irq_status_r & ~avs_writedata_i[`IRQ_WIDTH-1:0]);
    end else begin
      irq_status_r <= irq_event | irq_status_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_r & irq_mask_r);
    end
  end

endmodule

// File: bench/motion_io_checker.sv
`timescale 1ns/1ps

module motion_io_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // pins and core status
  input wire logic task_start_input_i,
  input wire logic jog_input_i,
  input wire logic target_in_window_i,
  input wire logic lag_in_window_i,
  input wire logic [5:0] preset_met_i,
  input wire logic task_interrupted_i,
  // design outputs
  input wire logic start_task_o,
  input wire logic [7:0] task_num_o,
  input wire logic advance_o,
  input wire logic resume_o,
  input wire logic jog_run_o,
  input wire logic target_reached_output_o,
  input wire logic lag_fault_output_o,
  input wire logic [5:0] position_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence bus_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence pin_rise(s);
    $rose(s);
  endsequence
  sequence pin_fall(s);
    $fell(s);
  endsequence

  target_follow_a: assert property (!$past(rst_i) |->
    target_reached_output_o == $past(target_in_window_i)) else $error("in-position lags window");
  lag_follow_a: assert property (!$past(rst_i) |->
    lag_fault_output_o == $past(lag_in_window_i)) else $error("lag output wrong");
  flag_follow_a: assert property (!$past(rst_i) |->
    position_flag_o[4:1] == $past(preset_met_i[4:1])) else $error("position flag wrong");
  flag_edge_a: assert property ((position_flag_o[0] |-> $past(preset_met_i[0])) and
    (position_flag_o[5] |-> $past(preset_met_i[5]))) else $error("flag without preset");
  num_hold_a: assert property (!$past(rst_i) && !start_task_o |->
    $stable(task_num_o)) else $error("task number moved");
  advance_gate_a: assert property (advance_o |->
    $past(target_in_window_i)) else $error("advance before target");
  resume_gate_a: assert property (resume_o |->
    $past(task_interrupted_i)) else $error("resume not allowed");
  bus_answer_a: assert property (bus_req |=> !avs_waitrequest_o)
    else $error("bus not answered");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  start_latency_a: assert property (pin_rise(task_start_input_i) |->
    ##[2:8] start_task_o) else $error("start missed");
  jog_start_a: assert property (pin_rise(jog_input_i) |-> ##[2:8] jog_run_o)
    else $error("jog did not start");
  jog_stop_a: assert property (pin_fall(jog_input_i) |-> ##[2:8] !jog_run_o)
    else $error("jog did not stop");
endmodule

bind motion_task_io_card motion_io_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .task_start_input_i(task_start_input_i),
  .jog_input_i(jog_input_i), .target_in_window_i(target_in_window_i),
  .lag_in_window_i(lag_in_window_i), .preset_met_i(preset_met_i),
  .task_interrupted_i(task_interrupted_i), .start_task_o(start_task_o),
  .task_num_o(task_num_o), .advance_o(advance_o), .resume_o(resume_o),
  .jog_run_o(jog_run_o), .target_reached_output_o(target_reached_output_o),
  .lag_fault_output_o(lag_fault_output_o), .position_flag_o(position_flag_o)
);

// File: bench/plc_model.sv
`timescale 1ns/1ps

module plc_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request from the bench
  input wire logic [7:0] num_i,
  input wire logic go_i,
  // pins towards the card
  output logic [7:0] task_select_o,
  output logic task_start_o
);
  logic [3:0] step_r;
  // ----------------------------------------------------------------
  // number set up ahead of the strobe, inverted on the same edge that drops the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_r <= 4'h0;
      task_select_o <= 8'h00;
      task_start_o <= 1'b0;
    end else if (step_r == 4'h0) begin
      if (go_i) begin
        task_select_o <= num_i;
        step_r <= 4'h1;
      end
    end else begin
      step_r <= step_r + 4'h1;
      if (step_r == 4'h2) task_start_o <= 1'b1;
      if (step_r == 4'h8) begin
        task_start_o <= 1'b0;
        // lines stop holding the number on the same edge that ends the strobe
        task_select_o <= ~task_select_o;
        step_r <= 4'h0;
      end
    end
  end
endmodule

// File: bench/motion_task_io_card_tb_top.sv
`timescale 1ns/1ps
`include "motion_io_params.svh"
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, ac); end end

module motion_task_io_card_tb_top
  import motion_io_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0, wr = 1'b0, go = 1'b0, e = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rv, ctrl;
  logic waitreq, irq, start_pin, start_o, adv_o, res_o, hom_o, jog_o, jdir_o, tgt_o, seq_o, lag_o;
  logic hom_pin = 1'b0, clr_pin = 1'b0, adv_pin = 1'b0, jog_pin = 1'b0, res_pin = 1'b0;
  logic base_hom = 1'b0, base_start = 1'b0, base_adv = 1'b0, base_res = 1'b0;
  logic in_win = 1'b0, lag_win = 1'b1, intr = 1'b0, seq_st = 1'b0, seq_first = 1'b0;
  logic lag_set = 1'b0, resp_set = 1'b0;
  logic [5:0] preset = 6'h00, flags_o;
  task_num_t go_num = 8'h00, base_sel = 8'h00, sel_pins, num_o, n;
  logic [15:0] jspd_o, m;
  int err_total = 0, compares = 0, st_cnt = 0, adv_cnt = 0, res_cnt = 0, k;
  int seed = 32'h65cf;

  motion_task_io_card uut (.clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .irq_o(irq), .task_select_i(sel_pins),
    .homing_switch_i(hom_pin), .lag_warning_clear_i(clr_pin), .advance_task_input_i(adv_pin),
    .jog_input_i(jog_pin), .resume_task_input_i(res_pin), .task_start_input_i(start_pin),
    .base_task_select_i(base_sel), .base_homing_i(base_hom), .base_task_start_i(base_start),
    .base_advance_i(base_adv), .base_resume_i(base_res), .target_in_window_i(in_win),
    .lag_in_window_i(lag_win), .preset_met_i(preset), .seq_task_start_i(seq_st),
    .seq_first_task_i(seq_first), .task_interrupted_i(intr), .lag_warn_set_i(lag_set),
    .resp_warn_set_i(resp_set), .start_task_o(start_o), .task_num_o(num_o), .advance_o(adv_o),
    .resume_o(res_o), .homing_o(hom_o), .jog_run_o(jog_o), .jog_speed_o(jspd_o),
    .jog_dir_o(jdir_o), .target_reached_output_o(tgt_o), .sequence_step_output_o(seq_o),
    .lag_fault_output_o(lag_o), .position_flag_o(flags_o));

  plc_model plc (.clk_i(clk), .rst_i(rst), .num_i(go_num), .go_i(go),
    .task_select_o(sel_pins), .task_start_o(start_pin));

  initial forever #2 clk = ~clk;

  // count pulses so slow checks cannot miss them
  always @(posedge clk) begin
    if (start_o === 1'b1) st_cnt++;
    if (adv_o === 1'b1) adv_cnt++;
    if (res_o === 1'b1) res_cnt++;
  end

  function automatic logic [15:0] jog_mag(input logic [15:0] v);
    return v[15] ? -v : v;
  endfunction
  function automatic logic seq_mode_exp(input int md, input logic win);
    return (md == 1) ? win : (md == 3);
  endfunction

  task tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (waitreq !== 1'b0 && t < 50) begin
      @(posedge clk);
      t++;
    end
    if (t >= 50) err_total++;
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task set_ctrl(input logic [31:0] v);
    ctrl = v;
    bus(1'b1, `OFS_CTRL, v);
    bus(1'b0, `OFS_CTRL, 32'h0);
    `CHK("ctrl reg", v, rv)
  endtask
  task pulse_seq(input logic f);
    seq_st <= 1'b1;
    seq_first <= f;
    tick(1);
    seq_st <= 1'b0;
    seq_first <= 1'b0;
    tick(3);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    err_total++;
    end_sim();
  end

  initial begin
    tick(8);
    rst <= 1'b0;
    tick(1);
    `CHK("waitrequest idle", 1'b1, waitreq)
    bus(1'b1, 4'hf, 32'hffffffff);
    bus(1'b0, 4'hf, 32'h0);
    `CHK("unmapped", 32'h0, rv)
    bus(1'b0, `OFS_JOG_SPEED, 32'h0);
    `CHK("jog reset", 32'h0, rv)
    for (int i = 0; i < 8; i++) begin
      n = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'hae : 8'($random(seed));
      k = st_cnt;
      go_num <= n;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(16);
      `CHK("start count", k + 1, st_cnt)
      `CHK("task number", n, num_o)
      bus(1'b0, `OFS_TASK, 32'h0);
      `CHK("task reg", {24'h0, n}, rv)
    end
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    bus(1'b1, `OFS_IRQ_STATUS, 32'hf);
    n = 8'($random(seed));
    base_sel <= n;
    base_start <= 1'b1;
    tick(1);
    base_start <= 1'b0;
    tick(6);
    `CHK("base number", n, num_o)
    `CHK("irq masked", 1'b0, irq)
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
    `CHK("irq status", 1'b1, rv[`IRQ_TASK_START])
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    tick(3);
    `CHK("irq raised", 1'b1, irq)
    bus(1'b1, `OFS_IRQ_STATUS, 32'h1);
    tick(3);
    `CHK("irq cleared", 1'b0, irq)
    for (int i = 0; i < 2; i++) begin
      m = {1'b0, 15'($random(seed))} | 16'h1;
      if (i == 0) m = -m;
      bus(1'b1, `OFS_JOG_SPEED, {16'h0, m});
      tick(2);
      `CHK("jog speed", jog_mag(m), jspd_o)
      `CHK("jog dir", m[15], jdir_o)
    end
    jog_pin <= 1'b1;
    tick(10);
    `CHK("jog run", 1'b1, jog_o)
    jog_pin <= 1'b0;
    tick(10);
    `CHK("jog stop", 1'b0, jog_o)
    k = adv_cnt;
    adv_pin <= 1'b1;
    tick(10);
    `CHK("advance held", k, adv_cnt)
    in_win <= 1'b1;
    tick(6);
    `CHK("advance go", k + 1, adv_cnt)
    `CHK("in position", 1'b1, tgt_o)
    adv_pin <= 1'b0;
    base_adv <= 1'b1;
    tick(1);
    base_adv <= 1'b0;
    tick(6);
    `CHK("base advance off", k + 1, adv_cnt)
    set_ctrl(32'h6);
    base_adv <= 1'b1;
    tick(1);
    base_adv <= 1'b0;
    tick(6);
    `CHK("base advance", k + 2, adv_cnt)
    k = res_cnt;
    res_pin <= 1'b1;
    tick(8);
    res_pin <= 1'b0;
    intr <= 1'b1;
    tick(8);
    `CHK("resume refused", k, res_cnt)
    res_pin <= 1'b1;
    tick(8);
    res_pin <= 1'b0;
    base_res <= 1'b1;
    tick(1);
    base_res <= 1'b0;
    tick(8);
    `CHK("resume", k + 2, res_cnt)
    for (int i = 0; i < 5; i++) begin
      pulse_seq(i == 0 || i == 3);
      e = (i == 0 || i == 3) ? 1'b0 : ~e;
      `CHK("sequence step", e, seq_o)
    end
    for (int md = 1; md < 4; md++) begin
      set_ctrl(ctrl & ~32'h18 | (md << `CTRL_SEQ_MODE_LO));
      tick(3);
      `CHK("sequence mode", seq_mode_exp(md, in_win), seq_o)
    end
    lag_set <= 1'b1;
    resp_set <= 1'b1;
    tick(1);
    lag_set <= 1'b0;
    resp_set <= 1'b0;
    tick(3);
    bus(1'b0, `OFS_WARN, 32'h0);
    `CHK("warnings set", 32'h3, rv)
    clr_pin <= 1'b1;
    tick(8);
    clr_pin <= 1'b0;
    bus(1'b0, `OFS_WARN, 32'h0);
    `CHK("warnings cleared", 32'h0, rv)
    hom_pin <= 1'b1;
    tick(8);
    `CHK("card homing", 1'b1, hom_o)
    set_ctrl(ctrl | 32'h1);
    tick(3);
    `CHK("card homing ignored", 1'b0, hom_o)
    base_hom <= 1'b1;
    tick(3);
    `CHK("base homing", 1'b1, hom_o)
    preset <= 6'h3f;
    lag_win <= 1'b0;
    in_win <= 1'b0;
    tick(3);
    `CHK("flags 1 to 4", 6'h1e, flags_o)
    `CHK("lag fault", 1'b0, lag_o)
    `CHK("left window", 1'b0, tgt_o)
    set_ctrl(ctrl | 32'h60);
    preset <= 6'($random(seed));
    lag_win <= 1'b1;
    tick(3);
    `CHK("all flags", preset, flags_o)
    `CHK("lag ok", 1'b1, lag_o)
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK("status reg", {20'h0, preset, 6'h0d}, rv)
    end_sim();
  end
endmodule
